//--- fcs_meas_model.sv
/*
 fcs_meas_model: stand-in for the measurement engine beside the block.
 Assumes the bench calls pulse() from one process at a time.
*/
`timescale 1ns/1ps
module fcs_meas_model
(
    // clock
    input  wire logic       clk_i,
    // per-channel one-cycle pulses
    output logic      [7:0] done_o,
    output logic      [7:0] ovf_o,
    output logic      [7:0] read_o
);
    initial
    begin
        done_o = 8'h00;
        ovf_o  = 8'h00;
        read_o = 8'h00;
    end

    // kind 0 new result, 1 overflow, 2 host read; dropped one edge later
    task automatic pulse(input int kind, input logic [7:0] m);
        @(posedge clk_i);
        if (kind == 0)
            done_o <= m;
        else if (kind == 1)
            ovf_o <= m;
        else
            read_o <= m;
        @(posedge clk_i);
        done_o <= 8'h00;
        ovf_o  <= 8'h00;
        read_o <= 8'h00;
    endtask
endmodule

//--- fcs_pkg.sv
/*
 fcs_pkg: shared constants for the frequency counter scan/status block.
 Assumes a 32-bit AHB-Lite register bus and eight measurement channels.
*/
package fcs_pkg;
    localparam int          FCS_NCH             = 8;
    // register byte offsets (low address byte only)
    localparam logic [7:0]  FCS_OFF_CTRL        = 8'h00;
    localparam logic [7:0]  FCS_OFF_FLAGS       = 8'h04;
    localparam logic [7:0]  FCS_OFF_RANGE       = 8'h08;
    localparam logic [7:0]  FCS_OFF_RANGE_FLAGS = 8'h0C;
    localparam logic [7:0]  FCS_OFF_FITTED      = 8'h10;
    localparam logic [7:0]  FCS_OFF_IRQ_STAT    = 8'h14;
    localparam logic [7:0]  FCS_OFF_IRQ_MASK    = 8'h18;
    // field positions
    localparam int          FCS_CTRL_SCAN_BIT   = 0;
    localparam int          FCS_CTRL_TEST_LSB   = 1;
    localparam int          FCS_CTRL_SINGLE_BIT = 3;
    localparam int          FCS_FLAGS_STALE_LSB = 8;
    localparam int          FCS_RANGE_FIRST_LSB = 0;
    localparam int          FCS_RANGE_LAST_LSB  = 8;
    localparam int          FCS_RFLAG_CLR_BIT   = 0;
    // values after reset
    localparam logic [3:0]  FCS_RST_FIRST       = 4'h1;
    localparam logic [3:0]  FCS_RST_LAST        = 4'h8;
    localparam logic [7:0]  FCS_RST_MASK        = 8'h00;
    localparam logic [7:0]  FCS_FITTED_CHANNELS = 8'h08;
    // self-test selection
    typedef enum logic [1:0]
    {
        FCS_SELFTEST_OFF   = 2'h0,
        FCS_SELFTEST_LOGIC = 2'h1,
        FCS_SELFTEST_DIFF  = 2'h2
    } fcs_selftest_type;
endpackage

//--- fcs_top.sv
/*
 fcs_top: scan control, self-test routing, stale/overflow flags and
 overflow interrupt of an eight-channel frequency counter.
 Assumes a single-master AHB-Lite bus on CLK_I and a measurement engine on
 the same clock giving one-cycle pulses per channel; front-end pins are async.
*/
// The register offsets and register access over AHB-Lite were decided locally.
// What this block does
// - software starts and stops continuous scanning
// - scan on/off state is readable
// - self-test replaces every channel's front-end input
// - self-test: off, logic-level path, differential path
// - selected self-test setting is readable
// - stale set on second read without news
// - overflow flag set on measurement overflow
// - flags readable over a channel range
// - range clear touches only channels inside range
// - fitted channel count is readable
// - interrupt mask bit n enables channel n+1
// - single scan clears counters, ends continuous scan
`timescale 1ns/1ps
module fcs_top
    import fcs_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RESETN_I,
    // AHB-Lite slave
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // measurement engine
    input  wire logic [7:0]  MEAS_DONE_I,
    input  wire logic [7:0]  MEAS_OVF_I,
    input  wire logic [7:0]  RESULT_READ_I,
    input  wire logic [7:0]  CHAN_TYPE_DIFF_I,
    // front-end pins
    input  wire logic [7:0]  FRONT_SE_I,
    input  wire logic [7:0]  FRONT_DIFF_I,
    input  wire logic        TEST_SE_I,
    input  wire logic        TEST_DIFF_I,
    // control outputs
    output logic      [7:0]  CHAN_IN_O,
    output logic             SCAN_RUN_O,
    output logic             COUNTER_CLEAR_O,
    output logic      [1:0]  SELFTEST_MODE_O,
    output logic             IRQ_O
);

    logic             rst_s1;
    logic             rst_n;
    logic [17:0]      sync1;
    logic [17:0]      sync2;
    logic [17:0]      sync3;
    logic [17:0]      pin_q;
    logic [17:0]      next_pin_q;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic             next_wr_pend;
    logic [7:0]       next_wr_addr;
    logic [31:0]      next_rdata;
    logic             continuous_scan_on;
    logic             next_scan;
    fcs_selftest_type mode;
    fcs_selftest_type next_mode;
    logic             next_clear;
    logic [3:0]       range_first_channel;
    logic [3:0]       range_last_channel;
    logic [3:0]       next_first;
    logic [3:0]       next_last;
    logic [7:0]       in_range;
    logic [7:0]       overflow_flag_vector;
    logic [7:0]       stale_flag_vector;
    logic [7:0]       read_once;
    logic [7:0]       next_ovf;
    logic [7:0]       next_stale;
    logic [7:0]       next_read_once;
    logic [7:0]       stale_set;
    logic [7:0]       range_clr;
    logic [7:0]       irq_stat;
    logic [7:0]       channel_select_mask;
    logic [7:0]       next_irq_stat;
    logic [7:0]       next_mask;
    logic             next_irq;
    logic [7:0]       next_chan_in;
    logic             addr_ok;
    logic             ctrl_wr;
    logic             single_req;
    logic [1:0]       wr_mode;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // pin filter: a change is taken only once stages two and three agree
    always_comb
    begin
        next_pin_q = (pin_q & (sync2 ^ sync3)) | (sync2 & ~(sync2 ^ sync3));
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= 18'h00000;
            sync2 <= 18'h00000;
            sync3 <= 18'h00000;
            pin_q <= 18'h00000;
        end
        else
        begin
            sync1 <= {TEST_DIFF_I, TEST_SE_I, FRONT_DIFF_I, FRONT_SE_I};
            sync2 <= sync1;
            sync3 <= sync2;
            pin_q <= next_pin_q;
        end
    end

    // channel range decode, channels numbered from one
    for (genvar k = 0; k < FCS_NCH; k++)
    begin : g_range
        assign in_range[k] = (4'(k + 1) >= range_first_channel) &&
                             (4'(k + 1) <= range_last_channel);
    end

    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;
    assign addr_ok     = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign ctrl_wr     = wr_pend && (wr_addr == FCS_OFF_CTRL);
    assign single_req  = ctrl_wr && HWDATA_I[FCS_CTRL_SINGLE_BIT];
    assign wr_mode     = HWDATA_I[FCS_CTRL_TEST_LSB +: 2];
    assign stale_set   = RESULT_READ_I & read_once & ~MEAS_DONE_I;

    always_comb
    begin
        next_wr_pend = addr_ok && HWRITE_I;
        next_wr_addr = HADDR_I[7:0];
        next_scan    = continuous_scan_on;
        next_mode    = mode;
        next_clear   = 1'b0;
        next_first   = range_first_channel;
        next_last    = range_last_channel;
        next_mask    = channel_select_mask;
        range_clr    = 8'h00;
        next_irq_stat = irq_stat & ~((wr_pend && wr_addr == FCS_OFF_IRQ_STAT) ?
                                     HWDATA_I[7:0] : 8'h00);
        if (ctrl_wr)
        begin
            next_scan = HWDATA_I[FCS_CTRL_SCAN_BIT];
            // the fourth code is no setting, so the old one is kept
            if (wr_mode != 2'h3)
            begin
                next_mode = fcs_selftest_type'(wr_mode);
            end
        end
        if (single_req)
        begin
            next_clear = 1'b1;
            next_scan  = 1'b0;
        end
        if (wr_pend && wr_addr == FCS_OFF_RANGE)
        begin
            next_first = HWDATA_I[FCS_RANGE_FIRST_LSB +: 4];
            next_last  = HWDATA_I[FCS_RANGE_LAST_LSB +: 4];
        end
        if (wr_pend && wr_addr == FCS_OFF_RANGE_FLAGS && HWDATA_I[FCS_RFLAG_CLR_BIT])
        begin
            range_clr = in_range;
        end
        if (wr_pend && wr_addr == FCS_OFF_IRQ_MASK)
        begin
            next_mask = HWDATA_I[7:0];
        end
        next_read_once = (read_once & ~MEAS_DONE_I) | RESULT_READ_I;
        next_stale     = stale_set | (stale_flag_vector & ~range_clr);
        next_ovf       = MEAS_OVF_I | (overflow_flag_vector & ~range_clr);
        next_irq_stat  = next_irq_stat | MEAS_OVF_I;
        next_irq       = |(next_irq_stat & next_mask);
        for (int c = 0; c < FCS_NCH; c++)
        begin
            case (next_mode)
                FCS_SELFTEST_LOGIC: next_chan_in[c] = pin_q[16];
                FCS_SELFTEST_DIFF:  next_chan_in[c] = pin_q[17];
                default:            next_chan_in[c] = CHAN_TYPE_DIFF_I[c] ?
                                                      pin_q[8 + c] : pin_q[c];
            endcase
        end
        // reads see this cycle's write, except that range-flag reads still mask with the old range during a range write
        next_rdata = HRDATA_O;
        if (addr_ok && !HWRITE_I)
        begin
            case (HADDR_I[7:0])
                FCS_OFF_CTRL:        next_rdata = {29'h0, next_mode, next_scan};
                FCS_OFF_FLAGS:       next_rdata = {16'h0, next_stale, next_ovf};
                FCS_OFF_RANGE:       next_rdata = {20'h0, next_last, 4'h0, next_first};
                FCS_OFF_RANGE_FLAGS: next_rdata = {16'h0, next_stale & in_range,
                                                   next_ovf & in_range};
                FCS_OFF_FITTED:      next_rdata = {24'h0, FCS_FITTED_CHANNELS};
                FCS_OFF_IRQ_STAT:    next_rdata = {24'h0, next_irq_stat};
                FCS_OFF_IRQ_MASK:    next_rdata = {24'h0, next_mask};
                default:             next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend              <= 1'b0;
            wr_addr              <= 8'h00;
            HRDATA_O             <= 32'h00000000;
            continuous_scan_on   <= 1'b0;
            mode                 <= FCS_SELFTEST_OFF;
            COUNTER_CLEAR_O      <= 1'b0;
            range_first_channel  <= FCS_RST_FIRST;
            range_last_channel   <= FCS_RST_LAST;
            overflow_flag_vector <= 8'h00;
            stale_flag_vector    <= 8'h00;
            read_once            <= 8'h00;
            irq_stat             <= 8'h00;
            channel_select_mask  <= FCS_RST_MASK;
            IRQ_O                <= 1'b0;
            CHAN_IN_O            <= 8'h00;
        end
        else
        begin
            wr_pend              <= next_wr_pend;
            wr_addr              <= next_wr_addr;
            HRDATA_O             <= next_rdata;
            continuous_scan_on   <= next_scan;
            mode                 <= next_mode;
            COUNTER_CLEAR_O      <= next_clear;
            range_first_channel  <= next_first;
            range_last_channel   <= next_last;
            overflow_flag_vector <= next_ovf;
            stale_flag_vector    <= next_stale;
            read_once            <= next_read_once;
            irq_stat             <= next_irq_stat;
            channel_select_mask  <= next_mask;
            IRQ_O                <= next_irq;
            CHAN_IN_O            <= next_chan_in;
        end
    end

    assign SCAN_RUN_O      = continuous_scan_on;
    assign SELFTEST_MODE_O = mode;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!rst_n);

    sequence s_single;
        single_req;
    endsequence

    property p_scan_start;
        (ctrl_wr && HWDATA_I[0] && !HWDATA_I[3]) |=> SCAN_RUN_O;
    endproperty
    a_scan_start: assert property (p_scan_start) else $error("scan did not start");

    property p_scan_read;
        (addr_ok && !HWRITE_I && HADDR_I[7:0] == FCS_OFF_CTRL && !wr_pend)
            |=> HRDATA_O[0] == SCAN_RUN_O && HRDATA_O[2:1] == SELFTEST_MODE_O;
    endproperty
    a_scan_read: assert property (p_scan_read) else $error("ctrl readback wrong");

    property p_test_route;
        (next_mode == FCS_SELFTEST_LOGIC) |=> CHAN_IN_O == {8{$past(pin_q[16])}};
    endproperty
    a_test_route: assert property (p_test_route) else $error("self-test not routed");

    property p_mode_legal;
        (ctrl_wr && wr_mode == 2'h3) |=> $stable(SELFTEST_MODE_O) && SELFTEST_MODE_O != 2'h3;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal self-test mode");

    property p_stale;
        (|stale_set) |=> (stale_flag_vector & $past(stale_set)) == $past(stale_set);
    endproperty
    a_stale: assert property (p_stale) else $error("stale flag not set");

    property p_ovf;
        (|MEAS_OVF_I) |=> (overflow_flag_vector & $past(MEAS_OVF_I)) == $past(MEAS_OVF_I);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");

    property p_range_clr;
        (|range_clr && MEAS_OVF_I == 8'h00) |=>
            overflow_flag_vector == ($past(overflow_flag_vector) & ~$past(range_clr));
    endproperty
    a_range_clr: assert property (p_range_clr) else $error("range clear wrong");

    property p_fitted;
        (addr_ok && !HWRITE_I && HADDR_I[7:0] == FCS_OFF_FITTED)
            |=> HRDATA_O == {24'h0, FCS_FITTED_CHANNELS};
    endproperty
    a_fitted: assert property (p_fitted) else $error("fitted count wrong");

    property p_irq;
        (MEAS_OVF_I[0] && channel_select_mask[0]
         && !(wr_pend && wr_addr == FCS_OFF_IRQ_MASK)) |=> IRQ_O;
    endproperty
    a_irq: assert property (p_irq) else $error("masked-in overflow gave no irq");

    property p_single;
        s_single |=> COUNTER_CLEAR_O && !SCAN_RUN_O ##1 !COUNTER_CLEAR_O;
    endproperty
    a_single: assert property (p_single) else $error("single scan misbehaved");

    property p_set_wins;
        (|(stale_set & range_clr)) |=>
            (stale_flag_vector & $past(stale_set)) == $past(stale_set);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

    property p_irq_set_wins;
        (|MEAS_OVF_I) |=> (irq_stat & $past(MEAS_OVF_I)) == $past(MEAS_OVF_I);
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins) else $error("irq event lost");
endmodule

//--- freq_counter_scan_status_tb.sv
/*
 freq_counter_scan_status_tb: register-level tests over AHB-Lite.
 Assumes zero-wait slave and the engine model driving the pulse inputs.
*/
`timescale 1ns/1ps
module freq_counter_scan_status_tb;
    import fcs_pkg::*;
    logic        clk, rstn, hsel, hwrite, tse, tdf;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic        hrdy, hresp, clr, scan, irq;
    logic [7:0]  done, ovf, rd, ctyp, fse, fdf, chin;
    logic [1:0]  mode;
    logic [7:0]  exp_in [3];
    int          bad_count, cmp_count;

    fcs_meas_model mdl (.clk_i(clk), .done_o(done), .ovf_o(ovf), .read_o(rd));
    fcs_top dut (
        .CLK_I(clk), .RESETN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
        .HREADYOUT_O(hrdy), .HRESP_O(hresp), .MEAS_DONE_I(done),
        .MEAS_OVF_I(ovf), .RESULT_READ_I(rd), .CHAN_TYPE_DIFF_I(ctyp),
        .FRONT_SE_I(fse), .FRONT_DIFF_I(fdf), .TEST_SE_I(tse),
        .TEST_DIFF_I(tdf), .CHAN_IN_O(chin), .SCAN_RUN_O(scan),
        .COUNTER_CLEAR_O(clr), .SELFTEST_MODE_O(mode), .IRQ_O(irq));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask

    // bounded wait for hready sampled high at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hrdy !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                bad_count++;
                report_and_stop();
            end
            @(posedge clk);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h000000, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(r, exp);
        chk(hresp, 32'h00000000);
    endtask

    initial
    begin
        {hsel, hwrite, tse, tdf} = 4'h0;
        htrans = 2'h0;
        haddr  = 32'h00000000;
        hwdata = 32'h00000000;
        ctyp   = 8'h0F;
        fse    = 8'h5A;
        fdf    = 8'hFF;
        exp_in = '{8'h5F, 8'hFF, 8'h00};
        bad_count = 0;
        cmp_count = 0;
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(FCS_OFF_CTRL, 32'h00000000);
        rd_chk(FCS_OFF_FITTED, 32'h00000008);
        rd_chk(FCS_OFF_RANGE, 32'h00000801);
        rd_chk(8'h1C, 32'h00000000);
        $display("test reset values done");

        bus(1'b1, FCS_OFF_CTRL, 32'h00000001);
        chk(scan, 1'b1);
        rd_chk(FCS_OFF_CTRL, 32'h00000001);
        bus(1'b1, FCS_OFF_CTRL, 32'h00000000);
        chk(scan, 1'b0);
        $display("test scan on off done");

        // high test source, low differential source: the two self-test modes differ on every pin
        @(posedge clk);
        tse <= 1'b1;
        for (int m = 0; m < 3; m++)
        begin
            bus(1'b1, FCS_OFF_CTRL, m << 1);
            chk(mode, m);
            rd_chk(FCS_OFF_CTRL, m << 1);
            repeat (6) @(posedge clk);
            chk(chin, exp_in[m]);
        end
        bus(1'b1, FCS_OFF_CTRL, 32'h00000004);
        bus(1'b1, FCS_OFF_CTRL, 32'h00000006);
        rd_chk(FCS_OFF_CTRL, 32'h00000004);
        $display("test self-test modes done");

        mdl.pulse(0, 8'h0C);
        mdl.pulse(2, 8'h0C);
        mdl.pulse(2, 8'h04);
        rd_chk(FCS_OFF_FLAGS, 32'h00000400);
        bus(1'b1, FCS_OFF_IRQ_MASK, 32'h00000001);
        mdl.pulse(1, 8'h02);
        #1;
        chk(irq, 1'b0);
        mdl.pulse(1, 8'h01);
        #1;
        chk(irq, 1'b1);
        rd_chk(FCS_OFF_FLAGS, 32'h00000403);
        rd_chk(FCS_OFF_IRQ_STAT, 32'h00000003);
        bus(1'b1, FCS_OFF_IRQ_STAT, 32'h00000001);
        chk(irq, 1'b0);
        rd_chk(FCS_OFF_IRQ_STAT, 32'h00000002);
        $display("test stale overflow irq done");

        bus(1'b1, FCS_OFF_RANGE, 32'h00000302);
        rd_chk(FCS_OFF_RANGE_FLAGS, 32'h00000402);
        bus(1'b1, FCS_OFF_RANGE_FLAGS, 32'h00000001);
        rd_chk(FCS_OFF_FLAGS, 32'h00000001);
        $display("test range read clear done");

        // event lands in the data phase of the clearing write
        fork
            bus(1'b1, FCS_OFF_RANGE_FLAGS, 32'h00000001);
            begin
                @(posedge clk);
                mdl.pulse(2, 8'h04);
            end
        join
        rd_chk(FCS_OFF_FLAGS, 32'h00000401);
        fork
            bus(1'b1, FCS_OFF_IRQ_STAT, 32'h00000003);
            begin
                @(posedge clk);
                mdl.pulse(1, 8'h01);
            end
        join
        chk(irq, 1'b1);
        rd_chk(FCS_OFF_IRQ_STAT, 32'h00000001);
        $display("test set beats clear done");

        bus(1'b1, FCS_OFF_CTRL, 32'h00000001);
        bus(1'b1, FCS_OFF_CTRL, 32'h00000009);
        chk(clr, 1'b1);
        chk(scan, 1'b0);
        @(posedge clk);
        #1;
        chk(clr, 1'b0);
        rd_chk(FCS_OFF_CTRL, 32'h00000000);
        $display("test single scan done");
        report_and_stop();
    end
endmodule
